/* pdm_consts.svh */
// register offsets, field positions, reset values and steps of the peripheral dma channel
// Summary of operation
// RULE1: four 32-bit pointers, four 16-bit counters
// RULE2: half duplex: software programs one direction
// RULE3: counters readable anytime, show items left
// RULE4: control command bits enable/disable, status reports
// RULE5: pointer advances 1, 2 or 4
// RULE6: pointer rewrite mid-transfer continues at new address
// RULE7: current counter decrements per item, next untouched
// RULE8: current and next zero: stop, flag
// RULE9: next nonzero: reload current, clear next
// RULE10: rx end flag: counter zero; nonzero write clears
// RULE11: rx buffer full: both counters reach zero
// RULE12: tx end flag: counter zero; nonzero write clears
// RULE13: tx buffer empty: both zero; nonzero write clears
// RULE14: rx ready: request bus, read holding, write memory
// RULE15: tx ready: request bus, read memory, fill holding
// RULE16: completion flags go only to peripheral status
// RULE17: zero count stops, nonzero starts if enabled
// RULE18: half duplex: rx and tx views share registers
// RULE19: ten registers from 0x100, reset zero
// RULE20: rx enable acts only without rx disable
// RULE21: software never sets both enables in half duplex
// RULE22: status shows one per enabled direction
// RULE23: nonzero rx counter write clears buffer full
`ifndef PDM_CONSTS_SVH
`define PDM_CONSTS_SVH

`define PDM_OFF_RX_CUR_PTR  12'h100
`define PDM_OFF_RX_CUR_CNT  12'h104
`define PDM_OFF_TX_CUR_PTR  12'h108
`define PDM_OFF_TX_CUR_CNT  12'h10C
`define PDM_OFF_RX_NXT_PTR  12'h110
`define PDM_OFF_RX_NXT_CNT  12'h114
`define PDM_OFF_TX_NXT_PTR  12'h118
`define PDM_OFF_TX_NXT_CNT  12'h11C
`define PDM_OFF_CONTROL     12'h120
`define PDM_OFF_STATUS      12'h124

`define PDM_BIT_RX_ENABLE   0
`define PDM_BIT_RX_DISABLE  1
`define PDM_BIT_TX_ENABLE   8
`define PDM_BIT_TX_DISABLE  9

`define PDM_RESET_PTR       32'h0000_0000
`define PDM_RESET_CNT       16'h0000
`define PDM_RESET_WORD      32'h0000_0000

`define PDM_STEP_BYTE       32'h0000_0001
`define PDM_STEP_HALF       32'h0000_0002
`define PDM_STEP_WORD       32'h0000_0004

`endif

/* pdm_pkg.sv */
// types shared by the peripheral dma channel
`default_nettype none
package pdm_pkg;

  // channel sequencer, one-hot
  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0001,
    ST_RX_GRANT = 4'b0010,
    ST_RX_WRITE = 4'b0100,
    ST_TX_READ  = 4'b1000
  } pdm_state_t;

  // item width as given by the peripheral
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } pdm_size_t;

endpackage
`default_nettype wire

/* pdm_channel.sv */
// peripheral dma channel: register file, pointer/counter sets and transfer sequencer
//
// The implementer's own choice: register access over APB.
`default_nettype none
`include "pdm_consts.svh"

module pdm_channel #(
  parameter bit HALF_DUPLEX = 1'b0,
  parameter int ADDR_W      = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              clkEn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // serial peripheral side
  input  wire logic [1:0]        xferSize,
  input  wire logic              rxReady,
  input  wire logic [31:0]       rxHoldData,
  output logic                   rxHoldRead,
  input  wire logic              txReady,
  output logic      [31:0]       txHoldData,
  output logic                   txHoldWrite,
  output logic                   rxEndFlag,
  output logic                   rxBufFullFlag,
  output logic                   txEndFlag,
  output logic                   txBufEmptyFlag,
  output logic                   rxReqEnabled,
  output logic                   txReqEnabled,
  // bus matrix master port
  output logic                   memReq,
  input  wire logic              memGrant,
  output logic                   memWrite,
  output logic      [31:0]       memAddr,
  output logic      [31:0]       memWdata,
  output logic      [1:0]        memSize,
  input  wire logic [31:0]       memRdata,
  input  wire logic              memAck
);

  // a half duplex peripheral keeps only one physical set
  localparam int NSET = HALF_DUPLEX ? 1 : 2;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  pdm_pkg::pdm_state_t state_q;
  logic                actDir_q;      // 0 receive, 1 transmit
  logic [1:0]          size_q;
  logic [31:0]         buf_q;
  logic [31:0]         prdata_q;
  logic                peripheral_rx_trigger_q;
  logic                peripheral_tx_trigger_q;
  logic                rxEnd_q;
  logic                rxFull_q;
  logic                txEnd_q;
  logic                txEmpty_q;
  logic                rxHoldRead_q;
  logic                txHoldWrite_q;
  logic                txHoldWriteD;
  logic [31:0]         txHoldData_q;

  logic [31:0] curPtr_q [NSET];
  logic [15:0] curCnt_q [NSET];
  logic [31:0] nxtPtr_q [NSET];
  logic [15:0] nxtCnt_q [NSET];

  logic        wrEn;
  logic        rdSetup;
  logic        mapped;
  logic [31:0] rdValue;
  logic        stepDo;
  logic [31:0] stepBytes;
  logic        actSet;
  logic        rxSet;
  logic        txSet;
  logic        endEv;
  logic        bufEv;
  logic        rxCntWrNz;
  logic        txCntWrNz;
  logic        rxStart;
  logic        txStart;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, so the access phase is always the last

  assign pready  = 1'b1;
  assign wrEn    = clkEn & psel & penable & pwrite;
  assign rdSetup = clkEn & psel & ~penable & ~pwrite;
  assign pslverr = psel & penable & ~mapped;  // unmapped offsets answer with an error
  assign prdata  = prdata_q;

  // both views point at set 0 in half duplex mode
  assign rxSet  = 1'b0;
  assign txSet  = HALF_DUPLEX ? 1'b0 : 1'b1;  // see RULE18
  assign actSet = actDir_q ? txSet : rxSet;

  // a nonzero write to either counter of a direction clears its flags
  assign rxCntWrNz = wrEn & (pwdata[15:0] != 16'h0000) &
                     ((paddr == `PDM_OFF_RX_CUR_CNT) | (paddr == `PDM_OFF_RX_NXT_CNT));
  assign txCntWrNz = wrEn & (pwdata[15:0] != 16'h0000) &
                     ((paddr == `PDM_OFF_TX_CUR_CNT) | (paddr == `PDM_OFF_TX_NXT_CNT));

  // read multiplexer; counters return the live items left
  always_comb begin
    mapped  = 1'b1;
    rdValue = `PDM_RESET_WORD;
    case (paddr)
      `PDM_OFF_RX_CUR_PTR: rdValue = curPtr_q[rxSet];
      `PDM_OFF_RX_CUR_CNT: rdValue = {16'h0000, curCnt_q[rxSet]};  // see RULE3
      `PDM_OFF_TX_CUR_PTR: rdValue = curPtr_q[txSet];
      `PDM_OFF_TX_CUR_CNT: rdValue = {16'h0000, curCnt_q[txSet]};  // see RULE3
      `PDM_OFF_RX_NXT_PTR: rdValue = nxtPtr_q[rxSet];
      `PDM_OFF_RX_NXT_CNT: rdValue = {16'h0000, nxtCnt_q[rxSet]};
      `PDM_OFF_TX_NXT_PTR: rdValue = nxtPtr_q[txSet];
      `PDM_OFF_TX_NXT_CNT: rdValue = {16'h0000, nxtCnt_q[txSet]};
      `PDM_OFF_CONTROL:    rdValue = `PDM_RESET_WORD;  // write-only, reads zero
      `PDM_OFF_STATUS: begin
        rdValue[`PDM_BIT_RX_ENABLE] = peripheral_rx_trigger_q;  // see RULE22
        rdValue[`PDM_BIT_TX_ENABLE] = peripheral_tx_trigger_q;  // see RULE22
      end
      default:             mapped  = 1'b0;
    endcase
  end

  // read data is captured in the setup phase so it comes from a flip-flop
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= `PDM_RESET_WORD;
    end else if (rdSetup) begin
      prdata_q <= rdValue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request enables from the control register

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      peripheral_rx_trigger_q <= 1'b0;
      peripheral_tx_trigger_q <= 1'b0;
    end else if (wrEn && paddr == `PDM_OFF_CONTROL) begin
      if (HALF_DUPLEX) begin
        // one direction at a time; either disable stops both
        if (pwdata[`PDM_BIT_RX_DISABLE] || pwdata[`PDM_BIT_TX_DISABLE]) begin  // see RULE4
          peripheral_rx_trigger_q <= 1'b0;
          peripheral_tx_trigger_q <= 1'b0;
        end else if (pwdata[`PDM_BIT_RX_ENABLE]) begin  // see RULE20
          peripheral_rx_trigger_q <= 1'b1;
          peripheral_tx_trigger_q <= 1'b0;
        end else if (pwdata[`PDM_BIT_TX_ENABLE]) begin
          peripheral_rx_trigger_q <= 1'b0;
          peripheral_tx_trigger_q <= 1'b1;
        end
      end else begin
        // a zero bit leaves the state alone; disable beats enable
        if (pwdata[`PDM_BIT_RX_DISABLE]) begin  // see RULE4
          peripheral_rx_trigger_q <= 1'b0;
        end else if (pwdata[`PDM_BIT_RX_ENABLE]) begin  // see RULE20
          peripheral_rx_trigger_q <= 1'b1;
        end
        if (pwdata[`PDM_BIT_TX_DISABLE]) begin
          peripheral_tx_trigger_q <= 1'b0;
        end else if (pwdata[`PDM_BIT_TX_ENABLE]) begin
          peripheral_tx_trigger_q <= 1'b1;
        end
      end
    end
  end

  assign rxReqEnabled = peripheral_rx_trigger_q;
  assign txReqEnabled = peripheral_tx_trigger_q;

  ////////////////////////////////////////////////////////////////////////////
  // pointer and counter sets

  // step per item from the width latched at the start of the item
  always_comb begin
    case (size_q)
      pdm_pkg::SZ_BYTE: stepBytes = `PDM_STEP_BYTE;  // see RULE5
      pdm_pkg::SZ_HALF: stepBytes = `PDM_STEP_HALF;  // see RULE5
      default:          stepBytes = `PDM_STEP_WORD;  // see RULE5
    endcase
  end

  // the last item of the current count lands now
  assign endEv = stepDo & (curCnt_q[actSet] == 16'h0001);
  assign bufEv = endEv & (nxtCnt_q[actSet] == 16'h0000);

  // one physical set per view; half duplex keeps just one
  genvar s;
  generate
    for (s = 0; s < NSET; s++) begin : gSet
      logic selCurPtr;
      logic selCurCnt;
      logic selNxtPtr;
      logic selNxtCnt;
      logic hwStep;

      // in half duplex both views decode onto this one set
      assign selCurPtr = wrEn & (((paddr == `PDM_OFF_RX_CUR_PTR) & (rxSet == 1'(s))) |
                                 ((paddr == `PDM_OFF_TX_CUR_PTR) & (txSet == 1'(s))));  // see RULE18
      assign selCurCnt = wrEn & (((paddr == `PDM_OFF_RX_CUR_CNT) & (rxSet == 1'(s))) |
                                 ((paddr == `PDM_OFF_TX_CUR_CNT) & (txSet == 1'(s))));
      assign selNxtPtr = wrEn & (((paddr == `PDM_OFF_RX_NXT_PTR) & (rxSet == 1'(s))) |
                                 ((paddr == `PDM_OFF_TX_NXT_PTR) & (txSet == 1'(s))));
      assign selNxtCnt = wrEn & (((paddr == `PDM_OFF_RX_NXT_CNT) & (rxSet == 1'(s))) |
                                 ((paddr == `PDM_OFF_TX_NXT_CNT) & (txSet == 1'(s))));
      assign hwStep    = stepDo & (actSet == 1'(s)) & (curCnt_q[s] != 16'h0000);

      // hardware advance first, a software write in the same cycle wins
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          curPtr_q[s] <= `PDM_RESET_PTR;  // see RULE19
          curCnt_q[s] <= `PDM_RESET_CNT;
          nxtPtr_q[s] <= `PDM_RESET_PTR;
          nxtCnt_q[s] <= `PDM_RESET_CNT;
        end else if (clkEn) begin
          if (hwStep) begin
            if (curCnt_q[s] == 16'h0001 && nxtCnt_q[s] != 16'h0000) begin
              curPtr_q[s] <= nxtPtr_q[s];  // see RULE9
              curCnt_q[s] <= nxtCnt_q[s];  // see RULE9
              nxtPtr_q[s] <= `PDM_RESET_PTR;  // see RULE9
              nxtCnt_q[s] <= `PDM_RESET_CNT;  // see RULE9
            end else begin
              curPtr_q[s] <= curPtr_q[s] + stepBytes;  // see RULE5
              curCnt_q[s] <= curCnt_q[s] - 16'h0001;  // see RULE7
            end
          end
          if (selCurPtr) begin
            curPtr_q[s] <= pwdata;  // see RULE6
          end
          if (selCurCnt) begin
            curCnt_q[s] <= pwdata[15:0];  // see RULE1
          end
          if (selNxtPtr) begin
            nxtPtr_q[s] <= pwdata;
          end
          if (selNxtCnt) begin
            nxtCnt_q[s] <= pwdata[15:0];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // completion flags toward the peripheral status register; set wins over clear

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxEnd_q   <= 1'b0;
      rxFull_q  <= 1'b0;
      txEnd_q   <= 1'b0;
      txEmpty_q <= 1'b0;
    end else if (clkEn) begin
      if (endEv && !actDir_q) begin
        rxEnd_q <= 1'b1;  // see RULE10
      end else if (rxCntWrNz) begin
        rxEnd_q <= 1'b0;  // see RULE10
      end
      if (bufEv && !actDir_q) begin
        rxFull_q <= 1'b1;  // see RULE11
      end else if (rxCntWrNz) begin
        rxFull_q <= 1'b0;  // see RULE23
      end
      if (endEv && actDir_q) begin
        txEnd_q <= 1'b1;  // see RULE12
      end else if (txCntWrNz) begin
        txEnd_q <= 1'b0;  // see RULE12
      end
      if (bufEv && actDir_q) begin
        txEmpty_q <= 1'b1;  // see RULE13
      end else if (txCntWrNz) begin
        txEmpty_q <= 1'b0;  // see RULE13
      end
    end
  end

  // flags leave only toward the peripheral, never through these registers
  assign rxEndFlag      = rxEnd_q;  // see RULE16
  assign rxBufFullFlag  = rxFull_q;
  assign txEndFlag      = txEnd_q;
  assign txBufEmptyFlag = txEmpty_q;

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer; receive has priority when both are ready

  assign rxStart = peripheral_rx_trigger_q & rxReady & (curCnt_q[rxSet] != 16'h0000);  // see RULE17
  assign txStart = peripheral_tx_trigger_q & txReady & (curCnt_q[txSet] != 16'h0000);  // see RULE17

  // an item retires on the memory acknowledge
  assign stepDo = clkEn & memAck &
                  ((state_q == pdm_pkg::ST_RX_WRITE) | (state_q == pdm_pkg::ST_TX_READ));
  assign txHoldWriteD = memAck & (state_q == pdm_pkg::ST_TX_READ);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q      <= pdm_pkg::ST_IDLE;
      actDir_q     <= 1'b0;
      size_q       <= 2'b00;
      buf_q        <= `PDM_RESET_WORD;
      rxHoldRead_q <= 1'b0;
    end else if (clkEn) begin
      rxHoldRead_q <= 1'b0;
      case (state_q)
        pdm_pkg::ST_IDLE: begin
          if (rxStart) begin
            state_q  <= pdm_pkg::ST_RX_GRANT;  // see RULE14
            actDir_q <= 1'b0;
            size_q   <= xferSize;
          end else if (txStart) begin
            state_q  <= pdm_pkg::ST_TX_READ;  // see RULE15
            actDir_q <= 1'b1;
            size_q   <= xferSize;
          end
        end
        pdm_pkg::ST_RX_GRANT: begin
          if (memGrant) begin
            buf_q        <= rxHoldData;  // see RULE14
            rxHoldRead_q <= 1'b1;
            state_q      <= pdm_pkg::ST_RX_WRITE;
          end
        end
        pdm_pkg::ST_RX_WRITE: begin
          if (memAck) begin
            state_q <= pdm_pkg::ST_IDLE;  // see RULE8
          end
        end
        pdm_pkg::ST_TX_READ: begin
          if (memAck) begin
            state_q <= pdm_pkg::ST_IDLE;  // see RULE8
          end
        end
        default: state_q <= pdm_pkg::ST_IDLE;
      endcase
    end
  end

  // transmit holding register load, one pulse per item
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txHoldData_q  <= `PDM_RESET_WORD;
      txHoldWrite_q <= 1'b0;
    end else if (clkEn) begin
      txHoldWrite_q <= txHoldWriteD;
      if (txHoldWriteD) begin
        txHoldData_q <= memRdata;  // see RULE15
      end
    end
  end

  // peripheral side ports come straight from their flops

  assign txHoldData  = txHoldData_q;
  assign txHoldWrite = txHoldWrite_q;
  assign rxHoldRead  = rxHoldRead_q;

  // the address follows the live pointer so a rewrite takes effect at once
  assign memReq   = (state_q != pdm_pkg::ST_IDLE);
  assign memWrite = (state_q == pdm_pkg::ST_RX_WRITE);
  assign memAddr  = curPtr_q[actSet];  // see RULE6
  assign memWdata = buf_q;
  assign memSize  = size_q;

endmodule // pdm_channel
`default_nettype wire

/* pdm_channel_monitor.sv */
// concurrent checks on the ports of the peripheral dma channel
`default_nettype none
module pdm_channel_monitor #(
  parameter bit HALF_DUPLEX = 1'b0,
  parameter int ADDR_W      = 12
) (
  input wire logic              sys_clk,
  input wire logic              rstn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pslverr,
  input wire logic              rxHoldRead,
  input wire logic              txHoldWrite,
  input wire logic [31:0]       txHoldData,
  input wire logic              memReq,
  input wire logic              memWrite,
  input wire logic              memAck,
  input wire logic [31:0]       memRdata,
  input wire logic              rxEndFlag,
  input wire logic              rxBufFullFlag,
  input wire logic              txEndFlag,
  input wire logic              txBufEmptyFlag,
  input wire logic              rxReqEnabled,
  input wire logic              txReqEnabled
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic mapped;
  // the ten registers sit on aligned words from 0x100
  assign mapped = paddr >= ADDR_W'(12'h100) && paddr <= ADDR_W'(12'h124) && paddr[1:0] == 2'b00;
  ////////////////////////////////////////////////////////////////////////////
  a_unmapped_error: assert property (psel && penable |-> pslverr == !mapped)
    else $error("slave error does not follow the address map");
  a_request_enabled: assert property ($rose(memReq) |-> $past(rxReqEnabled || txReqEnabled))
    else $error("memory request while both directions disabled");
  a_request_holds: assert property (memReq && !memAck |=> memReq)
    else $error("memory request dropped before acknowledge");
  a_hold_read: assert property (rxHoldRead |-> memReq && memWrite ##1 !rxHoldRead)
    else $error("holding read outside the memory write phase");
  a_tx_fill: assert property (txHoldWrite |-> $past(memAck && !memWrite) && !memReq)
    else $error("transmit holding write without a memory read");
  a_tx_data: assert property (txHoldWrite |-> txHoldData == $past(memRdata))
    else $error("transmit holding data differs from memory data");
  a_rx_end_rise: assert property ($rose(rxEndFlag) |-> $past(memAck && memWrite))
    else $error("receive end flag rose without a memory write");
  a_tx_end_rise: assert property ($rose(txEndFlag) |-> txHoldWrite)
    else $error("transmit end flag rose without a holding write");
  a_rx_full_end: assert property ($rose(rxBufFullFlag) |-> rxEndFlag && $past(memAck && memWrite))
    else $error("receive buffer full rose apart from receive end");
  a_tx_empty_end: assert property ($rose(txBufEmptyFlag) |-> txEndFlag && txHoldWrite)
    else $error("transmit buffer empty rose apart from transmit end");
  a_half_single: assert property (!(HALF_DUPLEX && rxReqEnabled && txReqEnabled))
    else $error("both directions enabled on a half duplex channel");
endmodule // pdm_channel_monitor

bind pdm_channel pdm_channel_monitor #(.HALF_DUPLEX(HALF_DUPLEX), .ADDR_W(ADDR_W)) u_mon (
  .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .rxHoldRead(rxHoldRead), .txHoldWrite(txHoldWrite), .txHoldData(txHoldData), .memReq(memReq),
  .memWrite(memWrite), .memAck(memAck), .memRdata(memRdata), .rxEndFlag(rxEndFlag),
  .rxBufFullFlag(rxBufFullFlag), .txEndFlag(txEndFlag), .txBufEmptyFlag(txBufEmptyFlag),
  .rxReqEnabled(rxReqEnabled), .txReqEnabled(txReqEnabled));
`default_nettype wire

/* pdm_partner.sv */
// model of the serial peripheral and of the bus matrix memory port
`default_nettype none
module pdm_partner (
  input wire logic   sys_clk,
  input wire logic   rstn,
  input wire logic   slow,
  input wire logic [3:0] rxPost,
  input wire logic [3:0] txPost,
  input wire logic   rxHoldRead,
  input wire logic   txHoldWrite,
  input wire logic   memReq,
  input wire logic [31:0] memAddr,
  output logic       rxReady,
  output logic [31:0] rxHoldData,
  output logic       txReady,
  output logic       memGrant,
  output logic [31:0] memRdata,
  output logic       memAck,
  output logic [7:0] ackCnt_q,
  output logic [31:0] lastAddr_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] rxPend_q, txPend_q;
  logic [7:0] rxSeq_q, wait_q, dly;
  // pending items; a holding read or fill takes one away
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxPend_q <= '0;
      txPend_q <= '0;
      rxSeq_q  <= '0;
    end else begin
      rxPend_q <= rxPend_q + rxPost - 4'(rxHoldRead);
      txPend_q <= txPend_q + txPost - 4'(txHoldWrite);
      rxSeq_q  <= rxSeq_q + 8'(rxHoldRead);
    end
  end
  assign rxReady    = rxPend_q != 4'h0;
  assign txReady    = txPend_q != 4'h0 && !txHoldWrite; // holding register is full while written
  assign rxHoldData = 32'h5A5A_0000 | {24'h00_0000, rxSeq_q};
  // matrix grants after dly and acknowledges later; slow stretches both
  assign dly      = slow ? 8'h03 : 8'h00;
  assign memGrant = memReq && wait_q >= dly;
  assign memAck   = memReq && wait_q == 8'(2 * dly + 1);
  assign memRdata = memAck ? ~memAddr : {4{wait_q}}; // no stale value outside the answer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wait_q     <= '0;
      ackCnt_q   <= '0;
      lastAddr_q <= '0;
    end else begin
      wait_q <= (memReq && !memAck) ? wait_q + 8'h01 : 8'h00;
      if (memAck) begin
        ackCnt_q   <= ackCnt_q + 8'h01;
        lastAddr_q <= memAddr;
      end
    end
  end
endmodule // pdm_partner
`default_nettype wire

/* pdm_tb.sv */
// self-checking testbench of the peripheral dma channel
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct { logic [11:0] a; logic [31:0] w; logic [31:0] e; } pdm_row_t;
  logic        sys_clk, rstn, clkEn, psel, penable, pwrite, pready, pslverr, slow, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rxHoldData, txHoldData, memAddr, memWdata, memRdata, lastAddr, r;
  logic [1:0]  xferSize, memSize;
  logic [3:0]  rxPost, txPost;
  logic [7:0]  ackCnt;
  logic        rxReady, rxHoldRead, txReady, txHoldWrite, memReq, memGrant, memWrite, memAck;
  logic        rxEndFlag, rxBufFullFlag, txEndFlag, txBufEmptyFlag, rxReqEnabled, txReqEnabled;
  int          miscompares = 0, tests_run = 0;
  pdm_row_t rows [14] = '{
    '{12'h100, 32'hDEAD_BEEF, 32'hDEAD_BEEF}, '{12'h104, 32'h1234_ABCD, 32'h0000_ABCD},
    '{12'h108, 32'h8765_4321, 32'h8765_4321}, '{12'h10C, 32'hFFFF_FFFF, 32'h0000_FFFF},
    '{12'h110, 32'h0F0F_F0F0, 32'h0F0F_F0F0}, '{12'h114, 32'h5555_0001, 32'h0000_0001},
    '{12'h118, 32'hA5A5_5A5A, 32'hA5A5_5A5A}, '{12'h11C, 32'h0001_0000, 32'h0000_0000},
    '{12'h120, 32'h0000_0000, 32'h0000_0000}, '{12'h124, 32'h0000_0101, 32'h0000_0000},
    '{12'h128, 32'hFFFF_FFFF, 32'h0000_0000}, '{12'h104, 32'h0000_0000, 32'h0000_0000},
    '{12'h10C, 32'h0000_0000, 32'h0000_0000}, '{12'h114, 32'h0000_0000, 32'h0000_0000}};
  pdm_channel #(.HALF_DUPLEX(1'b0), .ADDR_W(12)) u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xferSize(xferSize), .rxReady(rxReady), .rxHoldData(rxHoldData), .rxHoldRead(rxHoldRead),
    .txReady(txReady), .txHoldData(txHoldData), .txHoldWrite(txHoldWrite), .rxEndFlag(rxEndFlag),
    .rxBufFullFlag(rxBufFullFlag), .txEndFlag(txEndFlag), .txBufEmptyFlag(txBufEmptyFlag),
    .rxReqEnabled(rxReqEnabled), .txReqEnabled(txReqEnabled), .memReq(memReq), .memGrant(memGrant),
    .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memSize(memSize),
    .memRdata(memRdata), .memAck(memAck));
  pdm_partner u_peer (
    .sys_clk(sys_clk), .rstn(rstn), .slow(slow), .rxPost(rxPost), .txPost(txPost),
    .rxHoldRead(rxHoldRead), .txHoldWrite(txHoldWrite), .memReq(memReq), .memAddr(memAddr),
    .rxReady(rxReady), .rxHoldData(rxHoldData), .txReady(txReady), .memGrant(memGrant),
    .memRdata(memRdata), .memAck(memAck), .ackCnt_q(ackCnt), .lastAddr_q(lastAddr));
  ////////////////////////////////////////////////////////////////////////////
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge; an idle cycle follows
  task automatic apb(input logic wrt, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wrt;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(r, exp);
  endtask
  // post one item to the peripheral model and wait for the memory answers
  task automatic item(input logic [1:0] sz, input bit rx, input logic [7:0] n);
    int t;
    t = 0;
    xferSize <= sz;
    if (rx) rxPost <= 4'h1;
    else txPost <= 4'h1;
    @(posedge sys_clk);
    rxPost <= 4'h0;
    txPost <= 4'h0;
    while (ackCnt !== n && t < 300) begin
      @(posedge sys_clk);
      t++;
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, xferSize, slow, rxPost, txPost} = '0;
    clkEn = 1'b1;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    check(e, 1'b0);
    rd(12'h128, 32'h0000_0000);
    check(e, 1'b1);
    $display("done: register table");
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 10; i++) rd(12'(12'h100 + 4 * i), 32'h0000_0000);
    $display("done: reset values");
    // receive: byte, half word, then reload into a word item
    wr(12'h100, 32'h0000_1000);
    wr(12'h104, 32'h0000_0002);
    wr(12'h110, 32'h0000_2000);
    wr(12'h114, 32'h0000_0001);
    wr(12'h120, 32'h0000_0001);
    rd(12'h124, 32'h0000_0001);
    item(2'b00, 1'b1, 8'h01);
    check(lastAddr, 32'h0000_1000);
    rd(12'h104, 32'h0000_0001);
    rd(12'h114, 32'h0000_0001);
    item(2'b01, 1'b1, 8'h02);
    check(lastAddr, 32'h0000_1001);
    check(rxEndFlag, 1'b1);
    check(rxBufFullFlag, 1'b0);
    item(2'b10, 1'b1, 8'h03);
    check(lastAddr, 32'h0000_2000);
    check(rxBufFullFlag, 1'b1);
    check(memWdata, 32'h5A5A_0002);
    check(memSize, 2'b10);
    rd(12'h100, 32'h0000_2004);
    rd(12'h110, 32'h0000_0000);
    rd(12'h114, 32'h0000_0000);
    item(2'b00, 1'b1, 8'h04);
    check(ackCnt, 8'h03);
    wr(12'h120, 32'h0000_0002);
    wr(12'h114, 32'h0000_0005);
    check({rxEndFlag, rxBufFullFlag}, 2'b00);
    wr(12'h120, 32'h0000_0003);
    rd(12'h124, 32'h0000_0000);
    $display("done: receive");
    // transmit against a slow matrix, pointer rewritten between items
    slow <= 1'b1;
    wr(12'h108, 32'h0000_3000);
    wr(12'h10C, 32'h0000_0002);
    wr(12'h120, 32'h0000_0100);
    rd(12'h124, 32'h0000_0100);
    item(2'b10, 1'b0, 8'h04);
    check(txHoldData, ~32'h0000_3000);
    rd(12'h10C, 32'h0000_0001);
    wr(12'h108, 32'h0000_4000);
    item(2'b10, 1'b0, 8'h05);
    check(lastAddr, 32'h0000_4000);
    check({txEndFlag, txBufEmptyFlag}, 2'b11);
    wr(12'h120, 32'h0000_0200);
    rd(12'h124, 32'h0000_0000);
    wr(12'h11C, 32'h0000_0001);
    check({txEndFlag, txBufEmptyFlag}, 2'b00);
    clkEn <= 1'b0;
    wr(12'h108, 32'h0000_BEEF);
    clkEn <= 1'b1;
    rd(12'h108, 32'h0000_4004);
    $display("done: transmit");
    conclude();
  end
endmodule // testbench
`default_nettype wire
